// ### verilog/restart_latch_pkg.sv
// Shared constants, types and gate function for the restart latch block
`default_nettype none
package restart_latch_pkg;
  // ************************************************************
  // Clock and time base
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int PULSE_MIN_MS = 500;
  localparam int PULSE_MAX_MS = 5000;
  localparam int BLINK_HALF_MS = 500;
  localparam int WIN_MIN_S = 6;
  localparam int WIN_MAX_S = 120;
  localparam int GATE_MAX_INPUTS = 7;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE = 8'h04;
  localparam logic [7:0] ADDR_WIN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_CLEAR_EN = 0;
  localparam int CTRL_REQ_EN = 1;
  localparam int CTRL_REQ_TYPE2 = 2;
  localparam int CTRL_EN_OUT = 3;
  localparam int CTRL_BLOCK_MAND = 4;
  localparam int CTRL_PRE_REQ_EN = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam int GATE_PCNT_LSB = 0;
  localparam int GATE_PFN_LSB = 4;
  localparam int GATE_RCNT_LSB = 8;
  localparam int GATE_RFN_LSB = 12;
  localparam logic [14:0] GATE_RESET = 15'h0101;
  localparam int WIN_SEC_LSB = 0;
  localparam int WIN_MAXBLK_LSB = 8;
  localparam logic [15:0] WIN_RESET = 16'h0106;
  localparam int ST_MON_Q = 0;
  localparam int ST_MON_REQ = 1;
  localparam int ST_MAN_Q = 2;
  localparam int ST_MAN_REQ = 3;
  localparam int ST_MMON_Q = 4;
  localparam int ST_MMON_REQ = 5;
  localparam int ST_PERM_GATE = 6;
  localparam int ST_PRE_Q = 7;
  localparam int ST_PRE_REQ = 8;
  localparam int ST_PRE_WAIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {GATE_AND, GATE_NAND, GATE_OR, GATE_NOR, GATE_XOR, GATE_XNOR} gate_func_type;

  // Gate over the low count inputs; a count of 0 or 1 passes input 0
  function automatic logic gate_eval(input logic [6:0] bits, input logic [2:0] count, input logic [2:0] func);
    logic [6:0] mask;
    logic all_v;
    logic any_v;
    logic par_v;
    mask = 7'((8'h01 << count) - 8'h01);
    all_v = &(bits | ~mask);
    any_v = |(bits & mask);
    par_v = ^(bits & mask);
    if (count <= 3'h1) begin
      return bits[0];
    end
    case (func)
      GATE_AND: return all_v;
      GATE_NAND: return ~all_v;
      GATE_OR: return any_v;
      GATE_NOR: return ~any_v;
      GATE_XOR: return par_v;
      GATE_XNOR: return ~par_v;
      default: return all_v;
    endcase
  endfunction : gate_eval
endpackage : restart_latch_pkg
`default_nettype wire

// ### verilog/input_filter.sv
// Three-stage pin synchroniser that accepts a level once two stages agree
`default_nettype none
module input_filter #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
    end else begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_reg[i] <= stage3_reg[i];
        end
      end
    end
  end

  assign level = level_reg;
endmodule : input_filter
`default_nettype wire

// ### verilog/restart_latch_unit.sv
// Restart latch operators: monitored, macro manual, macro monitored, pre-reset
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
// Behaviour
// - Clear or permit low forces monitored latch off
// - Idle monitored latch holds; request steady or blinking
// - Clear acts only when clear option enabled
// - Request output optional, steady or blinking type; blinking only on monitored request, macro requests steady
// - Macro latches take gated permit and restart
// - Macro manual latch sets on restart rising edge
// - Macro monitored latch sets on restart pulse
// - Permit gate 1-7 inputs, one bypasses
// - Restart gate 1-7 inputs, one bypasses
// - Gates offer AND NAND OR NOR XOR XNOR
// - Enable-out shows permit gate result
// - Button pulse valid only 500 ms to 5 s
// - Outer press accepted within 6-120 s window
// - Interruption count must be nonzero, within maximum
// - Pre-reset request high while window open
module restart_latch_unit
  import restart_latch_pkg::*;
#(
  parameter int MS_TICK_CYCLES = restart_latch_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic permit_in,
  input wire logic restart_in,
  input wire logic clear_in,
  input wire logic [6:0] permit_bits,
  input wire logic [6:0] restart_bits,
  input wire logic inner_button,
  input wire logic outer_button,
  output logic monitored_out,
  output logic monitored_request,
  output logic manual_out,
  output logic manual_request,
  output logic macro_monitored_out,
  output logic macro_monitored_request,
  output logic gate_enable_out,
  output logic prereset_out,
  output logic prereset_request
);
  import restart_latch_pkg::*;

  // Divider counter is 17 bits wide
  if (MS_TICK_CYCLES < 1 || MS_TICK_CYCLES > 131072) begin : gen_tick_check
    $error("MS_TICK_CYCLES out of range");
  end

  typedef enum logic [0:0] {PRE_IDLE, PRE_WAIT} pre_state_type;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [18:0] pins_s;
  logic permit_s, restart_s, clear_s, inner_s, outer_s;
  logic [6:0] pbits_s, rbits_s;

  input_filter #(.WIDTH(19)) u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .pin({outer_button, inner_button, restart_bits, permit_bits, clear_in, restart_in, permit_in}),
    .level(pins_s)
  );
  assign {outer_s, inner_s, rbits_s, pbits_s, clear_s, restart_s, permit_s} = pins_s;

  // ************************************************************
  // Register bus
  // ************************************************************
  logic [5:0] ctrl_reg;
  logic [14:0] gate_reg;
  logic [15:0] win_reg;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] status_word;

  wire aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
  wire w_take = s_axi_wvalid && !w_held_reg && !bvalid_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_ctrl = wr_fire && awaddr_reg == ADDR_CTRL;
  wire wr_gate = wr_fire && awaddr_reg == ADDR_GATE;
  wire wr_win = wr_fire && awaddr_reg == ADDR_WIN;
  wire wr_map = wr_ctrl || wr_gate || wr_win || (wr_fire && awaddr_reg == ADDR_STATUS);
  wire rd_take = s_axi_arvalid && !rvalid_reg;
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_word = 32'(ctrl_reg);
    end else if (s_axi_araddr == ADDR_GATE) begin
      rd_word = 32'(gate_reg);
    end else if (s_axi_araddr == ADDR_WIN) begin
      rd_word = 32'(win_reg);
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_word = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      rdata_reg <= 32'h00000000;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Configuration registers; only byte lanes 0 and 1 are used
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      gate_reg <= GATE_RESET;
      win_reg <= WIN_RESET;
    end else begin
      if (wr_ctrl && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[5:0];
      end
      if (wr_gate && wstrb_reg[0]) begin
        gate_reg[6:0] <= wdata_reg[6:0];
      end
      if (wr_gate && wstrb_reg[1]) begin
        gate_reg[14:8] <= wdata_reg[14:8];
      end
      if (wr_win && wstrb_reg[0]) begin
        win_reg[7:0] <= wdata_reg[7:0];
      end
      if (wr_win && wstrb_reg[1]) begin
        win_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ************************************************************
  // Options and gates
  // ************************************************************
  wire clear_en = ctrl_reg[CTRL_CLEAR_EN];
  wire req_en = ctrl_reg[CTRL_REQ_EN];
  wire req_type2 = ctrl_reg[CTRL_REQ_TYPE2];
  wire [2:0] perm_cnt = gate_reg[GATE_PCNT_LSB +: 3];
  wire [2:0] perm_fn = gate_reg[GATE_PFN_LSB +: 3];
  wire [2:0] rst_cnt = gate_reg[GATE_RCNT_LSB +: 3];
  wire [2:0] rst_fn = gate_reg[GATE_RFN_LSB +: 3];
  wire [6:0] win_sec = win_reg[WIN_SEC_LSB +: 7];
  wire [7:0] max_blocks = win_reg[WIN_MAXBLK_LSB +: 8];
  wire eff_clear = clear_en && clear_s;
  wire perm_gate = gate_eval(pbits_s, perm_cnt, perm_fn);
  wire rst_gate = gate_eval(rbits_s, rst_cnt, rst_fn);

  // ************************************************************
  // Millisecond tick and blink
  // ************************************************************
  logic [16:0] div_reg;
  logic [9:0] blink_cnt_reg;
  logic blink_reg;
  wire ms_tick = div_reg == 17'(MS_TICK_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_reg <= 17'h00000;
      blink_cnt_reg <= 10'h000;
      blink_reg <= 1'b0;
    end else begin
      div_reg <= ms_tick ? 17'h00000 : div_reg + 17'h00001;
      if (ms_tick) begin
        blink_cnt_reg <= (blink_cnt_reg == 10'(BLINK_HALF_MS - 1)) ? 10'h000 : blink_cnt_reg + 10'h001;
        blink_reg <= (blink_cnt_reg == 10'(BLINK_HALF_MS - 1)) ? ~blink_reg : blink_reg;
      end
    end
  end

  // ************************************************************
  // Latches
  // ************************************************************
  logic restart_d_reg, rst_gate_d_reg, permit_d_reg, inner_d_reg, outer_d_reg;
  logic mon_q_reg, mon_arm_reg, man_q_reg, mmon_q_reg, mmon_arm_reg, gate_out_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      restart_d_reg <= 1'b0;
      rst_gate_d_reg <= 1'b0;
      mon_q_reg <= 1'b0;
      mon_arm_reg <= 1'b0;
      man_q_reg <= 1'b0;
      mmon_q_reg <= 1'b0;
      mmon_arm_reg <= 1'b0;
      gate_out_reg <= 1'b0;
    end else begin
      restart_d_reg <= restart_s;
      rst_gate_d_reg <= rst_gate;
      gate_out_reg <= ctrl_reg[CTRL_EN_OUT] && perm_gate;
      // monitored latch: arm on rise, set on fall
      if (eff_clear || !permit_s) begin
        mon_q_reg <= 1'b0;
        mon_arm_reg <= 1'b0;
      end else if (restart_s && !restart_d_reg) begin
        mon_arm_reg <= 1'b1;
      end else if (!restart_s && restart_d_reg && mon_arm_reg) begin
        mon_q_reg <= 1'b1;
        mon_arm_reg <= 1'b0;
      end
      // macro manual on restart gate rising edge
      if (eff_clear || !perm_gate) begin
        man_q_reg <= 1'b0;
      end else if (rst_gate && !rst_gate_d_reg) begin
        man_q_reg <= 1'b1;
      end
      // macro monitored on restart gate pulse
      if (eff_clear || !perm_gate) begin
        mmon_q_reg <= 1'b0;
        mmon_arm_reg <= 1'b0;
      end else if (rst_gate && !rst_gate_d_reg) begin
        mmon_arm_reg <= 1'b1;
      end else if (!rst_gate && rst_gate_d_reg && mmon_arm_reg) begin
        mmon_q_reg <= 1'b1;
        mmon_arm_reg <= 1'b0;
      end
    end
  end

  // request outputs; monitored type 1 steady or type 2 blinking, manual and macro monitored steady
  wire mon_blocked = eff_clear || !permit_s;
  wire mon_req1 = !mon_blocked && !mon_q_reg;
  wire mon_req2 = mon_blocked || (!mon_q_reg && blink_reg);
  assign monitored_out = mon_q_reg;
  assign monitored_request = req_en && (req_type2 ? mon_req2 : mon_req1);
  assign manual_out = man_q_reg;
  assign manual_request = req_en && !eff_clear && perm_gate && !man_q_reg;
  assign macro_monitored_out = mmon_q_reg;
  assign macro_monitored_request = req_en && !eff_clear && perm_gate && !mmon_q_reg;
  assign gate_enable_out = gate_out_reg;

  // ************************************************************
  // Pre-reset sequencer
  // ************************************************************
  pre_state_type pre_state_reg;
  logic [12:0] inner_ms_reg, outer_ms_reg;
  logic [16:0] win_ms_reg;
  logic [7:0] blocks_reg;
  logic pre_q_reg;
  wire [6:0] win_clamped = (win_sec < 7'(WIN_MIN_S)) ? 7'(WIN_MIN_S) :
                           (win_sec > 7'(WIN_MAX_S)) ? 7'(WIN_MAX_S) : win_sec;
  wire [16:0] win_limit = 17'(win_clamped * MS_PER_S);
  wire inner_ok = !inner_s && inner_d_reg && inner_ms_reg >= 13'(PULSE_MIN_MS) && inner_ms_reg <= 13'(PULSE_MAX_MS);
  wire outer_ok = !outer_s && outer_d_reg && outer_ms_reg >= 13'(PULSE_MIN_MS) && outer_ms_reg <= 13'(PULSE_MAX_MS);
  wire win_over = win_ms_reg >= win_limit;
  wire blocks_ok = !ctrl_reg[CTRL_BLOCK_MAND] || (blocks_reg != 8'h00 && blocks_reg <= max_blocks);
  wire permit_fell = !permit_s && permit_d_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_state_reg <= PRE_IDLE;
      inner_d_reg <= 1'b0;
      outer_d_reg <= 1'b0;
      permit_d_reg <= 1'b0;
      inner_ms_reg <= 13'h0000;
      outer_ms_reg <= 13'h0000;
      win_ms_reg <= 17'h00000;
      blocks_reg <= 8'h00;
      pre_q_reg <= 1'b0;
    end else begin
      inner_d_reg <= inner_s;
      outer_d_reg <= outer_s;
      permit_d_reg <= permit_s;
      if (!inner_s) begin
        inner_ms_reg <= 13'h0000;
      end else if (ms_tick && inner_ms_reg != 13'h1FFF) begin
        inner_ms_reg <= inner_ms_reg + 13'h0001;
      end
      if (!outer_s) begin
        outer_ms_reg <= 13'h0000;
      end else if (ms_tick && outer_ms_reg != 13'h1FFF) begin
        outer_ms_reg <= outer_ms_reg + 13'h0001;
      end
      // output clears on permit fall or clear
      if (eff_clear || permit_fell) begin
        pre_q_reg <= 1'b0;
      end
      case (pre_state_reg)
        PRE_IDLE: begin
          if (inner_ok) begin
            pre_state_reg <= PRE_WAIT;
            win_ms_reg <= 17'h00000;
            blocks_reg <= 8'h00;
          end
        end
        PRE_WAIT: begin
          if (ms_tick) begin
            win_ms_reg <= win_ms_reg + 17'h00001;
          end
          if (permit_fell && blocks_reg != 8'hFF) begin
            blocks_reg <= blocks_reg + 8'h01;
          end
          if (win_over) begin
            pre_state_reg <= PRE_IDLE;
          end else if (outer_ok) begin
            pre_state_reg <= PRE_IDLE;
            // set after inner then outer with permit high
            if (permit_s && !eff_clear && blocks_ok) begin
              pre_q_reg <= 1'b1;
            end
          end
        end
        default: pre_state_reg <= PRE_IDLE;
      endcase
    end
  end

  assign prereset_out = pre_q_reg;
  assign prereset_request = ctrl_reg[CTRL_PRE_REQ_EN] && pre_state_reg == PRE_WAIT;

  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_MON_Q] = mon_q_reg;
    status_word[ST_MON_REQ] = monitored_request;
    status_word[ST_MAN_Q] = man_q_reg;
    status_word[ST_MAN_REQ] = manual_request;
    status_word[ST_MMON_Q] = mmon_q_reg;
    status_word[ST_MMON_REQ] = macro_monitored_request;
    status_word[ST_PERM_GATE] = perm_gate;
    status_word[ST_PRE_Q] = pre_q_reg;
    status_word[ST_PRE_REQ] = prereset_request;
    status_word[ST_PRE_WAIT] = pre_state_reg == PRE_WAIT;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_mon_forced_off: assert property (mon_blocked |=> !mon_q_reg) else $error("monitored latch not forced off");
  chk_mon_hold_state: assert property (mon_q_reg && !mon_blocked |=> mon_q_reg) else $error("monitored latch lost");
  chk_mon_pulse_set: assert property (!mon_blocked && mon_arm_reg && !restart_s && restart_d_reg |=> mon_q_reg)
    else $error("monitored latch missed pulse");
  chk_clear_ignored: assert property (!clear_en && permit_s && mon_q_reg |=> mon_q_reg) else $error("clear not gated");
  chk_macro_edge_set: assert property (!eff_clear && perm_gate && $rose(rst_gate) |=> man_q_reg)
    else $error("macro manual missed edge");
  chk_gate_bypass: assert property (perm_cnt <= 3'h1 |-> perm_gate == pbits_s[0]) else $error("permit bypass wrong");
  chk_enout_off: assert property (!ctrl_reg[CTRL_EN_OUT] |=> !gate_enable_out) else $error("enable out leaked");
  chk_pulse_range: assert property ($rose(pre_state_reg == PRE_WAIT) |->
    $past(inner_ms_reg) >= 13'(PULSE_MIN_MS) && $past(inner_ms_reg) <= 13'(PULSE_MAX_MS))
    else $error("inner pulse out of range");
  chk_window_expiry: assert property (pre_state_reg == PRE_WAIT && win_over |=> pre_state_reg == PRE_IDLE)
    else $error("window not closed");
  chk_pre_request: assert property (pre_state_reg == PRE_WAIT && !win_over && outer_ok |=> !prereset_request)
    else $error("request outlived reset press");
endmodule : restart_latch_unit
`default_nettype wire

// ### tb/button_pair_model.sv
// Operator model of the inner and outer pre-reset buttons
`default_nettype none
module button_pair_model #(
  parameter int TICK = 10
) (
  input wire logic clk,
  output logic inner_button,
  output logic outer_button
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    inner_button = 1'h0;
    outer_button = 1'h0;
  end
  task automatic press(input logic outer, input int ms);
    @(posedge clk);
    if (outer) begin
      outer_button <= 1'h1;
    end else begin
      inner_button <= 1'h1;
    end
    repeat (ms * TICK) @(posedge clk);
    outer_button <= 1'h0;
    inner_button <= 1'h0;
    repeat (8) @(posedge clk);
  endtask : press
endmodule : button_pair_model
`default_nettype wire

// ### tb/safety_restart_latch_logic_test.sv
// Self-checking bench for the restart latch unit
`default_nettype none
`define CHECK(got, exp) check_val(32'(got), 32'(exp))
module safety_restart_latch_logic_test import restart_latch_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic permit_in = 1'h0, restart_in = 1'h0, clear_in = 1'h0;
  logic [6:0] permit_bits = 7'h00, restart_bits = 7'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic inner_button, outer_button, monitored_out, monitored_request, manual_out;
  logic manual_request, macro_monitored_out, macro_monitored_request;
  logic gate_enable_out, prereset_out, prereset_request;
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;

  restart_latch_unit #(.MS_TICK_CYCLES(TICK)) restart_latch_unit_i (.clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .permit_in, .restart_in, .clear_in,
    .permit_bits, .restart_bits, .inner_button, .outer_button, .monitored_out, .monitored_request,
    .manual_out, .manual_request, .macro_monitored_out, .macro_monitored_request, .gate_enable_out,
    .prereset_out, .prereset_request);
  button_pair_model #(.TICK(TICK)) button_pair_model_i (.clk, .inner_button, .outer_button);

  // ************************************************************
  // Bench helpers
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 100) begin
      fail_count++;
      end_of_test();
    end
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 100) begin
      fail_count++;
      end_of_test();
    end
  endtask : axi_read
  task automatic pulse_restart();
    restart_in <= 1'h1;
    settle();
    restart_in <= 1'h0;
    settle();
  endtask : pulse_restart
  function automatic logic ref_gate(input logic [2:0] b, input int f);
    logic [5:0] r;
    r = {~^b, ^b, ~|b, |b, ~&b, &b};
    return r[f];
  endfunction : ref_gate

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_regs();
    axi_read(ADDR_CTRL);
    `CHECK(rd, 32'h0);
    axi_read(ADDR_GATE);
    `CHECK(rd, 32'h0101);
    axi_read(ADDR_WIN);
    `CHECK(rd, 32'h0106);
    axi_read(8'h10);
    `CHECK({rd, rsp}, {32'h0, RESP_SLVERR});
    axi_write(8'h10, 32'h1);
    `CHECK(rsp, RESP_SLVERR);
  endtask : test_regs
  task automatic test_monitored();
    int n;
    logic prev;
    axi_write(ADDR_CTRL, 32'h3);
    permit_in <= 1'h1;
    settle();
    `CHECK({monitored_out, monitored_request}, 2'h1);
    restart_in <= 1'h1;
    settle();
    `CHECK(monitored_out, 1'h0);
    restart_in <= 1'h0;
    settle();
    `CHECK({monitored_out, monitored_request}, 2'h2);
    clear_in <= 1'h1;
    settle();
    `CHECK({monitored_out, monitored_request}, 2'h0);
    clear_in <= 1'h0;
    axi_write(ADDR_CTRL, 32'h2);
    pulse_restart();
    clear_in <= 1'h1;
    settle();
    `CHECK(monitored_out, 1'h1);
    clear_in <= 1'h0;
    axi_write(ADDR_CTRL, 32'h6);
    permit_in <= 1'h0;
    settle();
    `CHECK({monitored_out, monitored_request}, 2'h1);
    permit_in <= 1'h1;
    n = 0;
    prev = monitored_request;
    repeat (1100 * TICK) begin
      @(posedge clk);
      if (monitored_request !== prev) n++;
      prev = monitored_request;
    end
    `CHECK(n >= 2 && n <= 4, 1'h1);
    axi_write(ADDR_CTRL, 32'h0);
    settle();
    `CHECK(monitored_request, 1'h0);
  endtask : test_monitored
  task automatic test_gates();
    logic [6:0] pat [4] = '{7'h78, 7'h01, 7'h7B, 7'h07};
    axi_write(ADDR_CTRL, 32'h8);
    for (int f = 0; f < 6; f++) begin
      axi_write(ADDR_GATE, 32'h0103 | 32'(f << 4));
      for (int p = 0; p < 4; p++) begin
        permit_bits <= pat[p];
        settle();
        `CHECK(gate_enable_out, ref_gate(pat[p][2:0], f));
      end
    end
    axi_write(ADDR_GATE, 32'h0131);
    permit_bits <= 7'h7E;
    settle();
    `CHECK(gate_enable_out, 1'h0);
    axi_write(ADDR_CTRL, 32'h0);
    permit_bits <= 7'h01;
    settle();
    `CHECK(gate_enable_out, 1'h0);
  endtask : test_gates
  task automatic test_macro();
    axi_write(ADDR_CTRL, 32'h2);
    axi_write(ADDR_GATE, 32'h2201);
    restart_bits <= 7'h00;
    settle();
    `CHECK({manual_out, manual_request}, 2'h1);
    restart_bits <= 7'h02;
    settle();
    `CHECK({manual_out, manual_request, macro_monitored_out}, 3'h4);
    restart_bits <= 7'h00;
    settle();
    `CHECK({macro_monitored_out, macro_monitored_request}, 2'h2);
    permit_bits <= 7'h00;
    settle();
    `CHECK({manual_out, macro_monitored_out}, 2'h0);
  endtask : test_macro
  task automatic test_prereset();
    axi_write(ADDR_CTRL, 32'h20);
    permit_in <= 1'h1;
    button_pair_model_i.press(1'h0, 100);
    `CHECK(prereset_request, 1'h0);
    button_pair_model_i.press(1'h0, 600);
    `CHECK(prereset_request, 1'h1);
    button_pair_model_i.press(1'h1, 600);
    `CHECK({prereset_out, prereset_request}, 2'h2);
    permit_in <= 1'h0;
    settle();
    `CHECK(prereset_out, 1'h0);
    axi_write(ADDR_CTRL, 32'h30);
    permit_in <= 1'h1;
    button_pair_model_i.press(1'h0, 600);
    button_pair_model_i.press(1'h1, 600);
    `CHECK({prereset_out, prereset_request}, 2'h0);
    button_pair_model_i.press(1'h0, 600);
    permit_in <= 1'h0;
    settle();
    permit_in <= 1'h1;
    settle();
    button_pair_model_i.press(1'h1, 600);
    `CHECK(prereset_out, 1'h1);
  endtask : test_prereset

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    test_regs();
    test_monitored();
    test_gates();
    test_macro();
    test_prereset();
    end_of_test();
  end
endmodule : safety_restart_latch_logic_test
`default_nettype wire
